// ### rco_pkg.sv
// Shared constants for the reference clock output block
package rco_pkg;
    localparam logic [7:0] CTRL_ADDR       = 8'h00;
    localparam logic [7:0] SRC_ADDR        = 8'h04;
    localparam logic [7:0] CTRL_RESET      = 8'h10;
    localparam logic [7:0] CTRL_WR_MASK    = 8'h9F;
    localparam logic [7:0] SRC_RESET       = 8'h00;
    localparam int         CTRL_EN_BIT     = 7;
    localparam int         CTRL_DUTY_HI    = 4;
    localparam int         CTRL_DUTY_LO    = 3;
    localparam int         CTRL_DIV_HI     = 2;
    localparam int         CTRL_DIV_LO     = 0;
    localparam int         SRC_SEL_HI      = 3;
    localparam int         NUM_SOURCES     = 10;
    localparam int         DIV_CNT_W       = 7;
    localparam logic [2:0] DIV_NONE        = 3'h0;
    localparam logic [1:0] DUTY_ZERO       = 2'h0;
    localparam logic [1:0] DUTY_QUARTER    = 2'h1;
    localparam logic [1:0] DUTY_HALF       = 2'h2;
    localparam logic [1:0] DUTY_THREEQ     = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0] HTRANS_SEQ      = 2'h3;
endpackage

// ### rco_sync.sv
// Two-flop synchroniser for a bank of asynchronous levels
`timescale 1ns/1ns
module rco_sync #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### rco_divider.sv
// Power-of-two divider with duty shaping on a sampled source
`timescale 1ns/1ns
module rco_divider (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       src_rise,
    input  wire logic [2:0] div_sel,
    input  wire logic [1:0] duty_sel,
    output logic            div_out
);
    logic [rco_pkg::DIV_CNT_W-1:0] cnt_q;
    logic                          armed_q;
    logic [rco_pkg::DIV_CNT_W-1:0] last;
    logic [rco_pkg::DIV_CNT_W:0]   cnt_ext;
    logic [rco_pkg::DIV_CNT_W:0]   thr_quarter;
    logic [rco_pkg::DIV_CNT_W:0]   thr_half;
    logic [rco_pkg::DIV_CNT_W:0]   thr_threeq;
    logic [rco_pkg::DIV_CNT_W+1:0] period;
    logic [rco_pkg::DIV_CNT_W+2:0] period_x3;

    // Thresholds in source periods; at divide by two the 25% threshold is zero, so that duty gets no high period
    always_comb begin
        period      = {{(rco_pkg::DIV_CNT_W+1){1'b0}}, 1'b1} << div_sel;
        period_x3   = {1'b0, period} + {period, 1'b0};
        last        = rco_pkg::DIV_CNT_W'(period - 1'b1);
        cnt_ext     = {1'b0, cnt_q};
        thr_quarter = (rco_pkg::DIV_CNT_W+1)'(period >> 2);
        thr_half    = (rco_pkg::DIV_CNT_W+1)'(period >> 1);
        thr_threeq  = (rco_pkg::DIV_CNT_W+1)'(period_x3 >> 2);
    end

    // First source edge after enable opens the first whole period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (!run) begin
            armed_q <= 1'b0;
        end else if (src_rise) begin
            armed_q <= 1'b1;
        end
    end

    // Counter starts at zero on enable so the first period is whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (src_rise && armed_q) begin
            cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 1'b1;
        end
    end

    // High time compares the phase counter against fractions of the period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_out <= 1'b0;
        end else if (!run || !armed_q) begin
            div_out <= 1'b0;
        end else begin
            unique case (duty_sel)
                rco_pkg::DUTY_ZERO:    div_out <= 1'b0;
                rco_pkg::DUTY_QUARTER: div_out <= (cnt_ext < thr_quarter);
                rco_pkg::DUTY_HALF:    div_out <= (cnt_ext < thr_half);
                rco_pkg::DUTY_THREEQ:  div_out <= (cnt_ext < thr_threeq);
            endcase
        end
    end
endmodule

// ### rco_top.sv
// Reference clock output generator with AHB-Lite register slave
// Summary of operation
// - Output starts cleanly low after enable, first period whole, no runt pulse.
// - Clearing enable forces the output low immediately, combinationally.
// - Divider field divides the source by two to the field value, 1 to 128.
// - Duty field, divide by four and up: 11 75%, 10 50%, 01 25%, 00 output stays low; at divide by two 11 gives 50% and 01 stays low.
// - Duty applies only when dividing; undivided passes source with its own duty.
// - Duty high bit resets to one, default 50%; all else resets zero.
// - Divider and duty changes accepted while enabled; output may glitch.
// - In sleep the output freezes at its current level.
// - Source field picks system clock, five oscillators, four logic cells; rest reserved.
// - Clock drives both the pin and an internal peripheral output.
// - Unused control bits 6-5 and source bits 7-4 read as zero.
// - Control: enable bit 7, duty bits 4-3, divider bits 2-0, all read/write.
`timescale 1ns/1ns
module rco_top (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic                            hsel,
    input  wire logic [7:0]                      haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic      [31:0]                     hrdata,
    output logic                                 hreadyout,
    output logic                                 hresp,
    input  wire logic                            sleep_req,
    input  wire logic [rco_pkg::NUM_SOURCES-1:0] src_clk_in,
    output logic                                 ref_out_pin,
    output logic                                 ref_out_pin_oe,
    output logic                                 ref_clk_internal
);
    logic [7:0] ctrl_q;
    logic [3:0] src_q;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [rco_pkg::NUM_SOURCES-1:0] src_sync;
    logic       src_lvl;
    logic       src_valid;
    logic       src_prev_q;
    logic       src_rise;
    logic       gen_on;
    logic       run;
    logic       div_out;
    logic       undiv_q;
    logic       shaped;
    logic       frozen_q;
    logic       out_q;
    logic       sleep_meta_q;
    logic       sleep_q;
    logic       bus_act;

    logic [2:0] ref_divide_sel;
    logic [1:0] ref_duty_sel;
    assign gen_on         = ctrl_q[rco_pkg::CTRL_EN_BIT];
    assign ref_duty_sel   = ctrl_q[rco_pkg::CTRL_DUTY_HI:rco_pkg::CTRL_DUTY_LO];
    assign ref_divide_sel = ctrl_q[rco_pkg::CTRL_DIV_HI:rco_pkg::CTRL_DIV_LO];

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_act   = hsel && (htrans == rco_pkg::HTRANS_NONSEQ || htrans == rco_pkg::HTRANS_SEQ);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= bus_act && hwrite;
            wr_addr_q <= haddr;
        end
    end

    // Register writes land in the data phase; unimplemented bits never store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= rco_pkg::CTRL_RESET;
            src_q  <= rco_pkg::SRC_RESET[3:0];
        end else if (wr_pend_q) begin
            if (wr_addr_q == rco_pkg::CTRL_ADDR) begin
                ctrl_q <= hwdata[7:0] & rco_pkg::CTRL_WR_MASK;
            end else if (wr_addr_q == rco_pkg::SRC_ADDR) begin
                src_q <= hwdata[rco_pkg::SRC_SEL_HI:0];
            end
        end
    end

    // Read data registered at address phase acceptance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (hready) begin
            if (bus_act && !hwrite && haddr == rco_pkg::CTRL_ADDR) begin
                hrdata <= {24'h000000, ctrl_q};
            end else if (bus_act && !hwrite && haddr == rco_pkg::SRC_ADDR) begin
                hrdata <= {28'h0000000, src_q};
            end else begin
                hrdata <= '0;
            end
        end
    end

    rco_sync #(
        .W        (rco_pkg::NUM_SOURCES)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (src_clk_in),
        .sync_out (src_sync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_meta_q <= 1'b0;
            sleep_q      <= 1'b0;
        end else begin
            sleep_meta_q <= sleep_req;
            sleep_q      <= sleep_meta_q;
        end
    end

    // Source mux: index 0 is the system clock lane, codes 10..15 are absent
    assign src_valid = (src_q < 4'(rco_pkg::NUM_SOURCES));
    assign src_lvl   = src_valid ? src_sync[src_q] : 1'b0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_q <= 1'b0;
        end else if (!sleep_q) begin
            src_prev_q <= src_lvl;
        end
    end
    assign src_rise = src_lvl && !src_prev_q && !sleep_q;
    assign run      = gen_on && src_valid;

    rco_divider u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (run),
        .src_rise (src_rise),
        .div_sel  (ref_divide_sel),
        .duty_sel (ref_duty_sel),
        .div_out  (div_out)
    );

    // Undivided path follows the source only after a fresh low, avoiding a runt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            undiv_q <= 1'b0;
        end else if (!run) begin
            undiv_q <= 1'b0;
        end else if (!sleep_q) begin
            undiv_q <= src_lvl & (undiv_q | !src_prev_q);
        end
    end

    assign shaped = (ref_divide_sel == rco_pkg::DIV_NONE) ? undiv_q : div_out;

    // Sleep holds the last level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frozen_q <= 1'b0;
        end else if (!sleep_q) begin
            frozen_q <= shaped;
        end
    end
    assign out_q = sleep_q ? frozen_q : shaped;

    // Disable gates the output at once
    assign ref_out_pin      = out_q & gen_on;
    assign ref_clk_internal = out_q & gen_on;
    assign ref_out_pin_oe   = gen_on;

    property p_disable_low;
        @(posedge clk) disable iff (!rst_n)
        !gen_on |-> !ref_out_pin && !ref_clk_internal;
    endproperty
    a_disable_low: assert property (p_disable_low) else $error("output high while disabled");

    property p_reset_duty;
        @(posedge clk) $rose(rst_n) |-> ctrl_q == rco_pkg::CTRL_RESET;
    endproperty
    a_reset_duty: assert property (p_reset_duty) else $error("bad control reset value");

    property p_unused_zero;
        @(posedge clk) disable iff (!rst_n)
        ctrl_q[6:5] == 2'b00 && hrdata[31:8] == 24'h000000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused control bits set");

    property p_reserved_low;
        @(posedge clk) disable iff (!rst_n)
        (!src_valid && !sleep_q) [*3] |-> !ref_out_pin;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("output active on reserved source");

    property p_sleep_freeze;
        @(posedge clk) disable iff (!rst_n)
        sleep_q && $past(sleep_q) && gen_on && $past(gen_on) |-> $stable(ref_out_pin);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("output moved during sleep");

    property p_pin_internal;
        @(posedge clk) disable iff (!rst_n)
        ref_out_pin == ref_clk_internal;
    endproperty
    a_pin_internal: assert property (p_pin_internal) else $error("pin and internal clock differ");

    property p_duty_zero;
        @(posedge clk) disable iff (!rst_n)
        (ref_duty_sel == rco_pkg::DUTY_ZERO && ref_divide_sel != rco_pkg::DIV_NONE && !sleep_q) [*2] |-> !ref_out_pin;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("high time with zero duty");

    property p_start_clean;
        @(posedge clk) disable iff (!rst_n)
        $rose(gen_on) |-> !ref_out_pin;
    endproperty
    a_start_clean: assert property (p_start_clean) else $error("runt at enable");

    property p_write_ctrl;
        @(posedge clk) disable iff (!rst_n)
        wr_pend_q && wr_addr_q == rco_pkg::CTRL_ADDR |=> ctrl_q == ($past(hwdata[7:0]) & rco_pkg::CTRL_WR_MASK);
    endproperty
    a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");

    property p_oe_enable;
        @(posedge clk) disable iff (!rst_n)
        ref_out_pin_oe == ctrl_q[rco_pkg::CTRL_EN_BIT];
    endproperty
    a_oe_enable: assert property (p_oe_enable) else $error("pin enable differs from module enable");

    property p_read_ctrl;
        @(posedge clk) disable iff (!rst_n)
        hready && bus_act && !hwrite && haddr == rco_pkg::CTRL_ADDR |=> hrdata == {24'h000000, $past(ctrl_q)};
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read data wrong");

    property p_read_src;
        @(posedge clk) disable iff (!rst_n)
        hready && bus_act && !hwrite && haddr == rco_pkg::SRC_ADDR |=> hrdata == {28'h0000000, $past(src_q)};
    endproperty
    a_read_src: assert property (p_read_src) else $error("source read data wrong");

    property p_write_src;
        @(posedge clk) disable iff (!rst_n)
        wr_pend_q && wr_addr_q == rco_pkg::SRC_ADDR |=> src_q == $past(hwdata[rco_pkg::SRC_SEL_HI:0]);
    endproperty
    a_write_src: assert property (p_write_src) else $error("source write lost");

    property p_reset_src;
        @(posedge clk) $rose(rst_n) |-> src_q == rco_pkg::SRC_RESET[3:0];
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("bad source reset value");

    property p_undiv_low;
        @(posedge clk) disable iff (!rst_n)
        !sleep_q && !src_lvl |=> !undiv_q;
    endproperty
    a_undiv_low: assert property (p_undiv_low) else $error("undivided output high on low source");

    property p_div_idle;
        @(posedge clk) disable iff (!rst_n)
        !run |=> !div_out;
    endproperty
    a_div_idle: assert property (p_div_idle) else $error("divided output high while stopped");

    property p_ctrl_hold;
        @(posedge clk) disable iff (!rst_n)
        !wr_pend_q |=> $stable(ctrl_q);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without a write");

    property p_src_hold;
        @(posedge clk) disable iff (!rst_n)
        !wr_pend_q |=> $stable(src_q);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source changed without a write");

    property p_sleep_frozen;
        @(posedge clk) disable iff (!rst_n)
        sleep_q |=> $stable(frozen_q);
    endproperty
    a_sleep_frozen: assert property (p_sleep_frozen) else $error("held level moved during sleep");

    property p_reserved_idle;
        @(posedge clk) disable iff (!rst_n)
        !src_valid |=> !undiv_q && !div_out;
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) else $error("generator ran on reserved source");

    property p_wr_pend_clear;
        @(posedge clk) disable iff (!rst_n)
        hready && !(bus_act && hwrite) |=> !wr_pend_q;
    endproperty
    a_wr_pend_clear: assert property (p_wr_pend_clear) else $error("write pending without a write");
endmodule

// ### rco_src_model.sv
// Behavioural model of the ten clock sources feeding the block
`timescale 1ns/1ns
module rco_src_model (
    input  wire logic       clk,
    output logic      [9:0] src_clk
);
    int t = 0;
    initial src_clk = 10'h000;
    // Lane i toggles every 3+i cycles, always slower than clk/2
    always @(posedge clk) begin
        t <= t + 1;
        for (int i = 0; i < 10; i++) begin
            src_clk[i] <= ((t / (3 + i)) % 2) == 1;
        end
    end
endmodule

// ### reference_clock_output_tb_top.sv
// Self-checking bench for the reference clock output block
`timescale 1ns/1ns
module reference_clock_output_tb_top;
    logic        clk;
    logic        rst_n     = 1'b0;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic        sleep_req = 1'b0;
    logic [7:0]  haddr     = 8'h00;
    logic [1:0]  htrans    = 2'h0;
    logic [2:0]  hsize     = 3'h2;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] seed      = 32'hD5E3;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic        pin_oe;
    logic        pin_int;
    logic [9:0]  src;
    int          err_count  = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          hi;
    int          per;

    rco_src_model model (.clk(clk), .src_clk(src));
    rco_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sleep_req(sleep_req), .src_clk_in(src), .ref_out_pin(pin),
        .ref_out_pin_oe(pin_oe), .ref_clk_internal(pin_int));
    assign hready = hreadyout;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h0);
    endfunction

    function automatic int exp_per(input int i, input int d);
        return (2 * (3 + i)) << d;
    endfunction

    function automatic int exp_hi(input int i, input int d, input int dc);
        return (d == 0) ? 3 + i : exp_per(i, d) * dc / 4;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= rco_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    task automatic cfg(input int s, input int d, input int dc);
        bus(1'b1, rco_pkg::CTRL_ADDR, 32'h0);
        bus(1'b1, rco_pkg::SRC_ADDR, 32'(s));
        bus(1'b1, rco_pkg::CTRL_ADDR, 32'(128 + dc * 8 + d));
    endtask

    // High time and period of one whole output pulse, in clock cycles
    task automatic meas;
        while (pin !== 1'b0) @(posedge clk);
        while (pin !== 1'b1) @(posedge clk);
        hi = 0;
        while (pin === 1'b1) begin
            @(posedge clk);
            hi++;
        end
        per = hi;
        while (pin === 1'b0) begin
            @(posedge clk);
            per++;
        end
    endtask

    task automatic cnt(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            // Unknown level counts heavily so it can never pass
            hi += (pin === 1'b1) ? 1 : ((pin === 1'b0) ? 0 : 1000);
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (rst_n) chk(pin_int, pin);
        if (cyc == 40000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, rco_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h10);
        bus(1'b0, rco_pkg::SRC_ADDR, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        repeat (4) begin
            seed = lfsr(seed);
            bus(1'b1, rco_pkg::CTRL_ADDR, seed);
            bus(1'b0, rco_pkg::CTRL_ADDR, 32'h0);
            chk(rd, seed & 32'h9F);
            bus(1'b1, rco_pkg::SRC_ADDR, seed >> 8);
            bus(1'b0, rco_pkg::SRC_ADDR, 32'h0);
            chk(rd, (seed >> 8) & 32'hF);
        end
        for (int i = 0; i < 10; i++) begin
            cfg(i, 1, 2);
            meas();
            chk(per, exp_per(i, 1));
        end
        for (int d = 0; d < 8; d++) begin
            cfg(0, d, 2);
            meas();
            chk(hi, exp_hi(0, d, 2));
            chk(per, exp_per(0, d));
        end
        for (int dc = 1; dc < 4; dc++) begin
            cfg(1, 2, dc);
            meas();
            chk(hi, exp_hi(1, 2, dc));
        end
        cfg(1, 2, 0);
        cnt(200);
        chk(hi, 0);
        // Divider raised while running
        cfg(0, 2, 2);
        meas();
        bus(1'b1, rco_pkg::CTRL_ADDR, 32'h93);
        meas();
        meas();
        chk(per, exp_per(0, 3));
        while (pin !== 1'b1) @(posedge clk);
        chk(pin_oe, 1'b1);
        bus(1'b1, rco_pkg::CTRL_ADDR, 32'h13);
        #1;
        chk(pin, 1'b0);
        chk(pin_oe, 1'b0);
        cfg(0, 3, 2);
        while (pin !== 1'b1) @(posedge clk);
        sleep_req <= 1'b1;
        repeat (4) @(posedge clk);
        cnt(100);
        chk(hi, 100);
        // Reset in mid-run while the output is frozen high
        rst_n <= 1'b0;
        sleep_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(pin, 1'b0);
        rst_n <= 1'b1;
        bus(1'b0, rco_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h10);
        seed = lfsr(seed);
        cfg(10 + seed[7:0] % 6, 1, 2);
        cnt(300);
        chk(hi, 0);
        results();
    end
endmodule
